// >>> design/dma_cfg_pkg.sv
package dma_cfg_pkg;
    localparam int          NUM_CH       = 8;
    localparam int          CNT_W        = 16;
    localparam int          CFG_W        = 15;
    localparam int          ADDR_W       = 8;
    // register offsets
    localparam logic [7:0]  STATUS_OFS   = 8'h00;
    localparam logic [7:0]  CLEAR_OFS    = 8'h04;
    localparam logic [7:0]  CFG_BASE     = 8'h08;
    localparam logic [7:0]  COUNT_BASE   = 8'h0c;
    localparam logic [7:0]  CH_STRIDE    = 8'h14;
    // reset values
    localparam logic [31:0] CLEAR_RST    = 32'h0000_0000;
    localparam logic [14:0] CFG_RST      = 15'h0000;
    localparam logic [15:0] COUNT_RST    = 16'h0000;
    // flag nibble positions
    localparam int          FL_ANY       = 0;
    localparam int          FL_DONE      = 1;
    localparam int          FL_HALF      = 2;
    localparam int          FL_FAULT     = 3;
    // channel configuration fields
    localparam int          CF_ON        = 0;
    localparam int          CF_DONE_IE   = 1;
    localparam int          CF_HALF_IE   = 2;
    localparam int          CF_FAULT_IE  = 3;
    localparam int          CF_DIR       = 4;
    localparam int          CF_RELOAD    = 5;
    localparam int          CF_PSTEP     = 6;
    localparam int          CF_MSTEP     = 7;
    localparam int          CF_PW_LO     = 8;
    localparam int          CF_MW_LO     = 10;
    localparam int          CF_RANK_LO   = 12;
    localparam int          CF_COPY      = 14;
    // widths: 00 byte, 01 half word, 10 word, 11 reserved
    localparam logic [1:0]  WIDTH_8      = 2'h0;
    localparam logic [1:0]  WIDTH_16     = 2'h1;
    localparam logic [1:0]  WIDTH_32     = 2'h2;
    // rank: 00 low .. 11 very high
    localparam logic [1:0]  RANK_LOW     = 2'h0;
    localparam logic [1:0]  RANK_TOP     = 2'h3;
endpackage

// >>> design/dma_channel_regs.sv
// Overview of operation
// - one in fault-clear bit resets fault flag
// - one in halfway-clear bit resets halfway flag
// - one in done-clear bit resets done flag
// - one in any-clear bit resets any flag
// - clear nibble per channel: fault,halfway,done,any
// - bit 14 memory copy, change only off
// - bits 13:12 rank, change only off
// - bits 11:10 memory item width
// - bits 9:8 peripheral item width
// - bit 7 steps memory address
// - bit 6 steps peripheral address
// - bit 5 circular, else stop after round
// - bit 4 direction, one memory to peripheral
// - bit 3 enables fault interrupt
// - bit 2 enables halfway interrupt
// - bit 1 enables done interrupt
// - bit 0 turns channel on and off
// - eight channels, registers at fixed stride
// - clear and configuration reset to zero
// - transfer error sets fault flag
// - any event sets any-event flag
// - item count drops one per transfer
// - circular reloads count, else stops channel
`timescale 1ns/10ps
`default_nettype none
module dma_channel_regs #(
    parameter int NCH = dma_cfg_pkg::NUM_CH,
    parameter int CW  = dma_cfg_pkg::CNT_W
) (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          ce,
    input  wire logic [dma_cfg_pkg::ADDR_W-1:0] regAddr,
    input  wire logic [31:0]                   regWdata,
    input  wire logic                          regWr,
    input  wire logic                          regRd,
    output logic      [31:0]                   regRdata,
    input  wire logic [NCH-1:0]                xferOk,
    input  wire logic [NCH-1:0]                xferErr,
    output logic      [NCH-1:0]                channelOn,
    output logic      [NCH-1:0]                memoryCopyMode,
    output logic      [NCH-1:0][1:0]           channelRank,
    output logic      [NCH-1:0][1:0]           memWidth,
    output logic      [NCH-1:0][1:0]           periphWidth,
    output logic      [NCH-1:0]                memAddrStepEn,
    output logic      [NCH-1:0]                periphAddrStepEn,
    output logic      [NCH-1:0]                memToPeriph,
    output logic      [NCH-1:0][CW-1:0]        itemsLeft,
    output logic      [NCH-1:0]                chanIrq
);
    typedef struct packed {
        logic [NCH-1:0][dma_cfg_pkg::CFG_W-1:0] cfg;
        logic [NCH-1:0][CW-1:0]                 cnt;
        logic [NCH-1:0][CW-1:0]                 preset;
        logic [NCH-1:0][3:0]                    flags;
        logic [31:0]                            clr;
        logic [31:0]                            rdata;
        logic [NCH-1:0]                         irq;
    } state_s;

    state_s st_ff;
    state_s nxt_st;

    always_comb begin
        logic [7:0]    cfgOfs;
        logic [7:0]    cntOfs;
        logic [CW-1:0] dec;
        logic [3:0]    ev;
        logic [3:0]    clrBits;
        logic [14:0]   wcfg;
        nxt_st = st_ff;
        cfgOfs = '0;
        cntOfs = '0;
        dec = '0;
        ev = '0;
        clrBits = '0;
        wcfg = '0;
        nxt_st.rdata = 32'h0000_0000;
        if (regWr && regAddr == dma_cfg_pkg::CLEAR_OFS) begin
            nxt_st.clr = regWdata;
        end
        if (regRd) begin
            if (regAddr == dma_cfg_pkg::STATUS_OFS) begin
                nxt_st.rdata = st_ff.flags;
            end else if (regAddr == dma_cfg_pkg::CLEAR_OFS) begin
                nxt_st.rdata = st_ff.clr;
            end
        end
        for (int i = 0; i < NCH; i++) begin
            cfgOfs = 8'(dma_cfg_pkg::CFG_BASE + dma_cfg_pkg::CH_STRIDE * i);
            cntOfs = 8'(dma_cfg_pkg::COUNT_BASE + dma_cfg_pkg::CH_STRIDE * i);
            // software access to the channel's registers
            if (regRd && regAddr == cfgOfs) begin
                nxt_st.rdata = {17'h00000, st_ff.cfg[i]};
            end
            if (regRd && regAddr == cntOfs) begin
                nxt_st.rdata = {16'h0000, st_ff.cnt[i]};
            end
            if (regWr && regAddr == cfgOfs) begin
                wcfg = regWdata[14:0];
                // copy mode and rank are frozen while the channel runs
                if (st_ff.cfg[i][dma_cfg_pkg::CF_ON]) begin
                    wcfg[dma_cfg_pkg::CF_COPY] = st_ff.cfg[i][dma_cfg_pkg::CF_COPY];
                    wcfg[dma_cfg_pkg::CF_RANK_LO +: 2] =
                        st_ff.cfg[i][dma_cfg_pkg::CF_RANK_LO +: 2];
                end
                nxt_st.cfg[i] = wcfg;
            end
            // count is writable only while off; the written value becomes the preset
            if (regWr && regAddr == cntOfs && !st_ff.cfg[i][dma_cfg_pkg::CF_ON]) begin
                nxt_st.cnt[i] = regWdata[CW-1:0];
                nxt_st.preset[i] = regWdata[CW-1:0];
            end
            // transfer progress
            ev = '0;
            if (st_ff.cfg[i][dma_cfg_pkg::CF_ON] && xferErr[i]) begin
                ev[dma_cfg_pkg::FL_FAULT] = 1'b1;
            end
            if (st_ff.cfg[i][dma_cfg_pkg::CF_ON] && xferOk[i] && !xferErr[i]
                    && st_ff.cnt[i] != '0) begin
                dec = st_ff.cnt[i] - 1'b1;
                nxt_st.cnt[i] = dec;
                if (dec == (st_ff.preset[i] >> 1) && dec != '0) begin
                    ev[dma_cfg_pkg::FL_HALF] = 1'b1;
                end
                if (dec == '0) begin
                    ev[dma_cfg_pkg::FL_DONE] = 1'b1;
                    if (st_ff.cfg[i][dma_cfg_pkg::CF_RELOAD]) begin
                        nxt_st.cnt[i] = st_ff.preset[i];
                    end else begin
                        nxt_st.cfg[i][dma_cfg_pkg::CF_ON] = 1'b0;
                    end
                end
            end
            ev[dma_cfg_pkg::FL_ANY] = |ev[3:1];
            // write-one clear, a same-cycle event wins over the clear
            clrBits = '0;
            if (regWr && regAddr == dma_cfg_pkg::CLEAR_OFS) begin
                clrBits = regWdata[4*i +: 4];
            end
            nxt_st.flags[i] = (st_ff.flags[i] & ~clrBits) | ev;
            nxt_st.irq[i] =
                (nxt_st.flags[i][dma_cfg_pkg::FL_FAULT] && nxt_st.cfg[i][dma_cfg_pkg::CF_FAULT_IE])
                || (nxt_st.flags[i][dma_cfg_pkg::FL_HALF] && nxt_st.cfg[i][dma_cfg_pkg::CF_HALF_IE])
                || (nxt_st.flags[i][dma_cfg_pkg::FL_DONE]
                    && nxt_st.cfg[i][dma_cfg_pkg::CF_DONE_IE]);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff.cfg    <= '{default: dma_cfg_pkg::CFG_RST};
            st_ff.cnt    <= '{default: dma_cfg_pkg::COUNT_RST};
            st_ff.preset <= '{default: dma_cfg_pkg::COUNT_RST};
            st_ff.flags  <= '0;
            st_ff.clr    <= dma_cfg_pkg::CLEAR_RST;
            st_ff.rdata  <= 32'h0000_0000;
            st_ff.irq    <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_out
            assign channelOn[g]        = st_ff.cfg[g][dma_cfg_pkg::CF_ON];
            assign memoryCopyMode[g]   = st_ff.cfg[g][dma_cfg_pkg::CF_COPY];
            assign channelRank[g]      = st_ff.cfg[g][dma_cfg_pkg::CF_RANK_LO +: 2];
            assign memWidth[g]         = st_ff.cfg[g][dma_cfg_pkg::CF_MW_LO +: 2];
            assign periphWidth[g]      = st_ff.cfg[g][dma_cfg_pkg::CF_PW_LO +: 2];
            assign memAddrStepEn[g]    = st_ff.cfg[g][dma_cfg_pkg::CF_MSTEP];
            assign periphAddrStepEn[g] = st_ff.cfg[g][dma_cfg_pkg::CF_PSTEP];
            assign memToPeriph[g]      = st_ff.cfg[g][dma_cfg_pkg::CF_DIR];
            assign itemsLeft[g]        = st_ff.cnt[g];
        end
    endgenerate

    assign regRdata = st_ff.rdata;
    assign chanIrq  = st_ff.irq;
endmodule
`default_nettype wire

// >>> testbench/dma_channel_regs_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module dma_channel_regs_assertions #(
    parameter int NCH = 8,
    parameter int CW  = 16
) (
    input wire logic                   clk,
    input wire logic                   rst_n,
    input wire logic [7:0]             regAddr,
    input wire logic [31:0]            regWdata,
    input wire logic                   regWr,
    input wire logic                   regRd,
    input wire logic [31:0]            regRdata,
    input wire logic [NCH-1:0]         xferOk,
    input wire logic [NCH-1:0]         xferErr,
    input wire logic [NCH-1:0]         channelOn,
    input wire logic [NCH-1:0][1:0]    channelRank,
    input wire logic [NCH-1:0][1:0]    memWidth,
    input wire logic [NCH-1:0][CW-1:0] itemsLeft,
    input wire logic [NCH-1:0]         chanIrq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    wire wrCfg = regWr && regAddr == 8'h08;
    wire okOn = channelOn[0] && xferOk[0] && !xferErr[0];
    AST_RD_IDLE: assert property (!$past(regRd) |-> regRdata == 32'h0)
        else $error("read data outside read slot");
    AST_RST: assert property (disable iff (1'b0) !rst_n |=> channelOn == '0 && itemsLeft == '0)
        else $error("state not cleared by reset");
    AST_ON: assert property (wrCfg && regWdata[0] && !xferOk[0] |=> channelOn[0])
        else $error("channel not switched on");
    AST_LOCK: assert property (channelOn[0] |=> $stable(channelRank[0]))
        else $error("rank changed while on");
    AST_WIDTH: assert property (wrCfg |=> memWidth[0] == $past(regWdata[11:10]))
        else $error("memory width not written");
    AST_DEC: assert property (okOn && itemsLeft[0] > 1 |=> itemsLeft[0] == $past(itemsLeft[0]) - 1'b1)
        else $error("count not decremented");
    AST_END: assert property (okOn && itemsLeft[0] == 1 |=> itemsLeft[0] != 0 || !channelOn[0])
        else $error("channel kept on at zero");
    AST_IRQ_CLR: assert property (regWr && regAddr == 8'h04 && regWdata[3:0] == 4'hf
        && xferOk == '0 && xferErr == '0 |-> ##[1:2] !chanIrq[0])
        else $error("interrupt kept after clear");
    cover property (wrCfg && regWdata[0]);
    cover property (xferErr[0] && channelOn[0]);
    cover property (okOn && itemsLeft[0] == 1);
endmodule
bind dma_channel_regs dma_channel_regs_assertions #(.NCH(NCH), .CW(CW)) i_chk (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .xferOk(xferOk), .xferErr(xferErr),
    .channelOn(channelOn), .channelRank(channelRank), .memWidth(memWidth),
    .itemsLeft(itemsLeft), .chanIrq(chanIrq));
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic             clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic [7:0]       regAddr = 8'h0, okReq = 8'h0, errReq = 8'h0, xferOk, xferErr, chanIrq;
    logic [31:0]      regWdata = 32'h0, regRdata, st = 32'h0, cfg;
    logic [7:0][15:0] itemsLeft;
    logic [7:0]       channelOn, memoryCopyMode, memAddrStepEn, periphAddrStepEn, memToPeriph;
    logic [7:0][1:0]  channelRank, memWidth, periphWidth;
    logic [15:0]      rnd = 16'hacc3;
    int               n_mismatch = 0, check_count = 0;
    always #12.5 clk = ~clk;
    xfer_source i_xfer_source (.clk(clk), .okReq(okReq), .errReq(errReq),
        .xferOk(xferOk), .xferErr(xferErr));
    dma_channel_regs i_dma_channel_regs (.clk(clk), .rst_n(rst_n), .ce(1'b1),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .xferOk(xferOk), .xferErr(xferErr), .channelOn(channelOn),
        .memoryCopyMode(memoryCopyMode), .channelRank(channelRank), .memWidth(memWidth),
        .periphWidth(periphWidth), .memAddrStepEn(memAddrStepEn),
        .periphAddrStepEn(periphAddrStepEn), .memToPeriph(memToPeriph),
        .itemsLeft(itemsLeft), .chanIrq(chanIrq));
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        {regAddr, regWdata, regWr} <= {a, d, 1'b1};
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        {regAddr, regRd} <= {a, 1'b1};
        @(posedge clk);
        regRd <= 1'b0;
        #1 chk(regRdata, e);
        @(posedge clk);
    endtask
    task automatic ev(input logic [7:0] ok, input logic [7:0] er);
        {okReq, errReq} <= {ok, er};
        @(posedge clk);
        {okReq, errReq} <= 16'h0;
        repeat (2) @(posedge clk);
    endtask
    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h04, 32'h0);
        wr(8'hfc, 32'hffff_ffff);
        rd(8'hfc, 32'h0);
        for (int k = 0; k < 8; k++) begin
            rd(8'(8 + 20 * k), 32'h0);
            wr(8'(12 + 20 * k), 32'h4);
            rnd = lfsr(rnd);
            // stop mode, legal widths, channel on
            cfg = ({16'h0, rnd} & 32'h75de) | 32'h1;
            wr(8'(8 + 20 * k), cfg | 32'hffff_8000);
            wr(8'(8 + 20 * k), cfg ^ 32'h7000);
            rd(8'(8 + 20 * k), cfg);
            chk({21'h0, memoryCopyMode[k], channelRank[k], memWidth[k], periphWidth[k], memAddrStepEn[k], periphAddrStepEn[k], memToPeriph[k], channelOn[k]}, {21'h0, cfg[14:6], cfg[4], cfg[0]});
            ev(8'h0, 8'(1 << k));
            st |= 32'h9 << (4 * k);
            for (int n = 3; n >= 0; n--) begin
                ev(8'(1 << k), 8'h0);
                st |= (n == 2 ? 32'h5 : n == 0 ? 32'h3 : 32'h0) << (4 * k);
                chk({16'h0, itemsLeft[k]}, 32'(n));
            end
            rd(8'h00, st);
            rd(8'(8 + 20 * k), cfg & 32'h7ffe);
            chk({31'h0, channelOn[k]}, 32'h0);
            chk({31'h0, chanIrq[k]}, {31'h0, |cfg[3:1]});
            wr(8'h04, 32'h0);
            rd(8'h00, st);
            for (int b = 3; b >= 0; b--) begin
                wr(8'h04, (32'hf << b) << (4 * k));
                st &= ~(32'h1 << (4 * k + b));
                rd(8'h00, st);
            end
            chk({31'h0, chanIrq[k]}, 32'h0);
        end
        wrap_up;
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        wrap_up;
    end
endmodule
`default_nettype wire

// >>> testbench/xfer_source.sv
`timescale 1ns/10ps
`default_nettype none
module xfer_source (
    input  wire logic       clk,
    input  wire logic [7:0] okReq,
    input  wire logic [7:0] errReq,
    output logic      [7:0] xferOk,
    output logic      [7:0] xferErr
);
    // outcome reported one bus cycle after the request, as a single-cycle pulse
    initial {xferOk, xferErr} = 16'h0;
    always @(posedge clk) {xferOk, xferErr} <= {okReq, errReq};
endmodule
`default_nettype wire
